//--- common/hams_consts.svh
// constant definitions for the hub alert mask and squelch register bank
// assumes inclusion by the design modules of this block
`ifndef HAMS_CONSTS_SVH
`define HAMS_CONSTS_SVH

`define HAMS_OFS_STATUS 8'he8
`define HAMS_OFS_MASK 8'he9
`define HAMS_OFS_CFG 8'hee
`define HAMS_OFS_SQ3 8'hf4
`define HAMS_OFS_SQ12 8'hf5

`define HAMS_BIT_SUMMARY 7
`define HAMS_BIT_SUSP 4
`define HAMS_BIT_CFGD 3
`define HAMS_BIT_PWR 2
`define HAMS_BIT_KEEP_CLK 7
`define HAMS_BIT_LEVEL_MODE 6
`define HAMS_BIT_TOUT_LO 4
`define HAMS_SQ_LO_1 0
`define HAMS_SQ_LO_2 4

`define HAMS_RST_MASK 8'h00
`define HAMS_RST_CFG 8'h00
`define HAMS_RST_SQ 8'h00
`define HAMS_CFG_TOUT_95MS 2'h0
`define HAMS_CFG_WINDOW_MS 95

`define HAMS_PCT_NOMINAL 8'h64
`define HAMS_PCT_90 8'h5a
`define HAMS_PCT_80 8'h50
`define HAMS_PCT_70 8'h46
`define HAMS_PCT_60 8'h3c
`define HAMS_PCT_50 8'h32
`define HAMS_PCT_120 8'h78
`define HAMS_PCT_110 8'h6e

`endif

//--- common/hams_pkg.sv
// types for the hub alert mask and squelch register bank
// assumes hams_consts.svh sits beside it
package hams_pkg;
  typedef logic [2:0] hams_squelch_t;

  typedef struct packed {
    logic flag_q;
  } hams_flag_state_t;

  typedef struct packed {
    logic [2:0] mask_q;
    logic keep_clk_q;
    logic level_mode_q;
    hams_squelch_t sq3_q;
    hams_squelch_t sq2_q;
    hams_squelch_t sq1_q;
    logic summary_q;
    logic susp_prev_q;
    logic alert_n_q;
    logic gate_q;
    logic [7:0] rdata_q;
    logic rvalid_q;
  } hams_state_t;
endpackage

//--- hdl/hams_event_flag.sv
// one sticky event status flag, cleared by writing zero
// assumes clr_wr pulses for one cycle on a status write whose bit is zero
`timescale 1ns/1ps
`include "hams_consts.svh"
module hams_event_flag import hams_pkg::*; (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic set_evt,
  input wire logic clr_wr,
  output logic flag
);
  hams_flag_state_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    // set beats a clear landing in the same cycle
    if (set_evt) begin
      st_d.flag_q = 1'b1;
    end else if (clr_wr) begin
      st_d.flag_q = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign flag = st_q.flag_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_flag_holds_set: assert property (flag && !clr_wr |=> flag)
    else $error("flag dropped without a clearing write");
  a_flag_event_sets: assert property (set_evt |=> flag)
    else $error("event did not set flag");
endmodule // hams_event_flag

//--- hdl/hams_squelch_decode.sv
// maps a three-bit squelch code to its percentage of nominal
// assumes the code comes straight from a register field
`timescale 1ns/1ps
`include "hams_consts.svh"
module hams_squelch_decode import hams_pkg::*; (
  input hams_squelch_t code,
  output logic [7:0] pct
);
  always_comb begin
    unique case (code)
      3'h0: pct = `HAMS_PCT_NOMINAL;
      3'h1: pct = `HAMS_PCT_90;
      3'h2: pct = `HAMS_PCT_80;
      3'h3: pct = `HAMS_PCT_70;
      3'h4: pct = `HAMS_PCT_60;
      3'h5: pct = `HAMS_PCT_50;
      3'h6: pct = `HAMS_PCT_120;
      3'h7: pct = `HAMS_PCT_110;
    endcase
  end
endmodule // hams_squelch_decode

//--- hdl/hams_regs.sv
// alert mask, portable hub configuration and squelch registers with the alert pin
// assumes the serial slave port gives one-cycle read and write strobes with a byte address
`timescale 1ns/1ps
`include "hams_consts.svh"
module hams_regs import hams_pkg::*; (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic hub_suspended,
  input wire logic hub_configured,
  input wire logic port_power_updated,
  output logic alert_n,
  output logic internal_clock_gate,
  output hams_squelch_t port1_squelch_field,
  output hams_squelch_t port2_squelch_field,
  output hams_squelch_t port3_squelch_field,
  output logic [7:0] port1_squelch_pct,
  output logic [7:0] port2_squelch_pct,
  output logic [7:0] port3_squelch_pct
);
  hams_state_t st_q, st_d;

  logic wr_status, wr_mask, wr_cfg, wr_sq3, wr_sq12;
  logic evt_susp, evt_cfgd, evt_pwr;
  logic susp_flag, cfgd_flag, pwr_flag;
  logic unmasked_evt;
  logic [7:0] status_rd, mask_rd, cfg_rd, sq3_rd, sq12_rd;

  assign wr_status = reg_wr && (reg_addr == `HAMS_OFS_STATUS);
  assign wr_mask = reg_wr && (reg_addr == `HAMS_OFS_MASK);
  assign wr_cfg = reg_wr && (reg_addr == `HAMS_OFS_CFG);
  assign wr_sq3 = reg_wr && (reg_addr == `HAMS_OFS_SQ3);
  assign wr_sq12 = reg_wr && (reg_addr == `HAMS_OFS_SQ12);

  // suspend is a level from the hub core; only its rising edge is an event
  assign evt_susp = hub_suspended && !st_q.susp_prev_q;
  assign evt_cfgd = hub_configured;
  assign evt_pwr = port_power_updated;

  hams_event_flag u_flag_susp (
    .clock(clock),
    .rst_b(rst_b),
    .set_evt(evt_susp),
    .clr_wr(wr_status && !reg_wdata[`HAMS_BIT_SUSP]),
    .flag(susp_flag)
  );

  hams_event_flag u_flag_cfgd (
    .clock(clock),
    .rst_b(rst_b),
    .set_evt(evt_cfgd),
    .clr_wr(wr_status && !reg_wdata[`HAMS_BIT_CFGD]),
    .flag(cfgd_flag)
  );

  hams_event_flag u_flag_pwr (
    .clock(clock),
    .rst_b(rst_b),
    .set_evt(evt_pwr),
    .clr_wr(wr_status && !reg_wdata[`HAMS_BIT_PWR]),
    .flag(pwr_flag)
  );

  // mask_q[2] suspend, [1] configured, [0] power update
  assign unmasked_evt = (evt_susp && st_q.mask_q[2])
    || (evt_cfgd && st_q.mask_q[1])
    || (evt_pwr && st_q.mask_q[0]);

  always_comb begin
    status_rd = 8'h00;
    status_rd[`HAMS_BIT_SUMMARY] = st_q.summary_q;
    status_rd[`HAMS_BIT_SUSP] = susp_flag;
    status_rd[`HAMS_BIT_CFGD] = cfgd_flag;
    status_rd[`HAMS_BIT_PWR] = pwr_flag;
    mask_rd = 8'h00;
    mask_rd[`HAMS_BIT_SUSP -: 3] = st_q.mask_q;
    cfg_rd = 8'h00;
    cfg_rd[`HAMS_BIT_KEEP_CLK] = st_q.keep_clk_q;
    cfg_rd[`HAMS_BIT_LEVEL_MODE] = st_q.level_mode_q;
    cfg_rd[`HAMS_BIT_TOUT_LO +: 2] = `HAMS_CFG_TOUT_95MS;
    sq3_rd = 8'h00;
    sq3_rd[`HAMS_SQ_LO_1 +: 3] = st_q.sq3_q;
    sq12_rd = 8'h00;
    sq12_rd[`HAMS_SQ_LO_2 +: 3] = st_q.sq2_q;
    sq12_rd[`HAMS_SQ_LO_1 +: 3] = st_q.sq1_q;
  end

  always_comb begin
    st_d = st_q;
    st_d.susp_prev_q = hub_suspended;
    st_d.rvalid_q = reg_rd;
    if (wr_mask) begin
      st_d.mask_q = reg_wdata[`HAMS_BIT_SUSP -: 3];
    end
    if (wr_cfg) begin
      // timeout field is read only, so bits 5:4 of the write are dropped
      st_d.keep_clk_q = reg_wdata[`HAMS_BIT_KEEP_CLK];
      st_d.level_mode_q = reg_wdata[`HAMS_BIT_LEVEL_MODE];
    end
    if (wr_sq3) begin
      st_d.sq3_q = reg_wdata[`HAMS_SQ_LO_1 +: 3];
    end
    if (wr_sq12) begin
      st_d.sq2_q = reg_wdata[`HAMS_SQ_LO_2 +: 3];
      st_d.sq1_q = reg_wdata[`HAMS_SQ_LO_1 +: 3];
    end
    // a new unmasked event wins over a clearing write in the same cycle
    if (unmasked_evt) begin
      st_d.summary_q = 1'b1;
    end else if (wr_status && !reg_wdata[`HAMS_BIT_SUMMARY]) begin
      st_d.summary_q = 1'b0;
    end
    if (st_d.level_mode_q) begin
      st_d.alert_n_q = !hub_suspended;
    end else begin
      st_d.alert_n_q = !st_d.summary_q;
    end
    // without keep-clock the core may stop its clocks while suspended
    st_d.gate_q = hub_suspended && !st_d.keep_clk_q;
    st_d.rdata_q = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `HAMS_OFS_STATUS: st_d.rdata_q = status_rd;
        `HAMS_OFS_MASK: st_d.rdata_q = mask_rd;
        `HAMS_OFS_CFG: st_d.rdata_q = cfg_rd;
        `HAMS_OFS_SQ3: st_d.rdata_q = sq3_rd;
        `HAMS_OFS_SQ12: st_d.rdata_q = sq12_rd;
        default: st_d.rdata_q = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      st_q <= '0;
      st_q.mask_q <= 3'h0;
      st_q.keep_clk_q <= 1'(`HAMS_RST_CFG >> `HAMS_BIT_KEEP_CLK);
      st_q.level_mode_q <= 1'b0;
      st_q.sq3_q <= 3'h0;
      st_q.sq2_q <= 3'h0;
      st_q.sq1_q <= 3'h0;
      st_q.alert_n_q <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata_q;
  assign reg_rvalid = st_q.rvalid_q;
  assign alert_n = st_q.alert_n_q;
  assign internal_clock_gate = st_q.gate_q;
  assign port1_squelch_field = st_q.sq1_q;
  assign port2_squelch_field = st_q.sq2_q;
  assign port3_squelch_field = st_q.sq3_q;

  hams_squelch_decode u_dec1 (
    .code(st_q.sq1_q),
    .pct(port1_squelch_pct)
  );

  hams_squelch_decode u_dec2 (
    .code(st_q.sq2_q),
    .pct(port2_squelch_pct)
  );

  hams_squelch_decode u_dec3 (
    .code(st_q.sq3_q),
    .pct(port3_squelch_pct)
  );

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_event_mode;
    !st_q.level_mode_q && !wr_cfg;
  endsequence

  sequence s_susp_entry;
    $rose(hub_suspended) && st_q.mask_q[2];
  endsequence

  a_susp_alert_low: assert property (s_event_mode ##0 s_susp_entry |=> !alert_n)
    else $error("suspend entry did not pull alert low");
  a_cfgd_alert_low: assert property (s_event_mode ##0 hub_configured && st_q.mask_q[1] |=> !alert_n)
    else $error("configured event did not pull alert low");
  a_pwr_alert_low: assert property (s_event_mode ##0 port_power_updated && st_q.mask_q[0] |=> !alert_n)
    else $error("power update did not pull alert low");
  a_masked_no_alert: assert property (s_event_mode ##0 alert_n && !unmasked_evt |=> alert_n)
    else $error("alert fell without an unmasked event");
  a_clock_gate_follow: assert property (hub_suspended && !st_q.keep_clk_q && !wr_cfg |=> internal_clock_gate)
    else $error("clock not gated in suspend");
  a_keep_clock_run: assert property (st_q.keep_clk_q && !wr_cfg |=> !internal_clock_gate)
    else $error("clock gated while keep-clock set");
  a_level_mode_pin: assert property (st_q.level_mode_q && !wr_cfg |=> alert_n == !$past(hub_suspended))
    else $error("level mode alert does not track suspend");
  a_summary_clear: assert property (wr_status && !reg_wdata[7] && !unmasked_evt && !st_q.level_mode_q && !wr_cfg
    |=> alert_n && !st_q.summary_q)
    else $error("summary clear did not release alert");
  a_summary_keep: assert property (wr_status && reg_wdata[7] && st_q.summary_q |=> st_q.summary_q)
    else $error("writing one changed summary");
  a_timeout_field: assert property (reg_rvalid && $past(reg_addr) == `HAMS_OFS_CFG |-> reg_rdata[5:0] == 6'h00)
    else $error("config read shows nonzero timeout or reserved bits");
  a_sq12_reserved: assert property (reg_rvalid && $past(reg_addr) == `HAMS_OFS_SQ12
    |-> !reg_rdata[7] && !reg_rdata[3])
    else $error("squelch reserved bits read nonzero");
  a_sq_write_lands: assert property (wr_sq12 ##1 1'b1 |-> port2_squelch_field == $past(reg_wdata[6:4])
    && port1_squelch_field == $past(reg_wdata[2:0]))
    else $error("port 1/2 squelch write lost");

  // read answer one edge after the strobe, zero otherwise
  sequence s_read_back(logic [7:0] a);
    reg_rvalid && $past(reg_addr) == a;
  endsequence

  sequence s_unmapped_read;
    reg_rd && reg_addr != `HAMS_OFS_STATUS && reg_addr != `HAMS_OFS_MASK
      && reg_addr != `HAMS_OFS_CFG && reg_addr != `HAMS_OFS_SQ3 && reg_addr != `HAMS_OFS_SQ12;
  endsequence

  a_rvalid_pulse: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe gave no valid");

  a_rdata_idle: assert property (!reg_rd |=> !reg_rvalid && reg_rdata == 8'h00)
    else $error("read data not idle without a read");

  a_unmapped_zero: assert property (s_unmapped_read |=> reg_rdata == 8'h00)
    else $error("unmapped read returned nonzero");

  a_mask_read_clean: assert property (s_read_back(`HAMS_OFS_MASK)
    |-> reg_rdata[7:5] == 3'h0 && reg_rdata[1:0] == 2'h0)
    else $error("mask reserved bits read nonzero");

  a_sq3_read_clean: assert property (s_read_back(`HAMS_OFS_SQ3) |-> reg_rdata[7:3] == 5'h00)
    else $error("port 3 squelch reserved bits read nonzero");

  a_status_read_clean: assert property (s_read_back(`HAMS_OFS_STATUS)
    |-> reg_rdata[6:5] == 2'h0 && reg_rdata[1:0] == 2'h0)
    else $error("status reserved bits read nonzero");

  // register writes land one edge later and nothing else moves them
  a_mask_write_lands: assert property (wr_mask |=> st_q.mask_q == $past(reg_wdata[4:2]))
    else $error("mask write lost");

  a_mask_holds: assert property (!wr_mask |=> $stable(st_q.mask_q))
    else $error("mask changed without a write");

  a_cfg_write_lands: assert property (wr_cfg
    |=> st_q.keep_clk_q == $past(reg_wdata[7]) && st_q.level_mode_q == $past(reg_wdata[6]))
    else $error("config write lost");

  a_cfg_holds: assert property (!wr_cfg |=> $stable(st_q.keep_clk_q) && $stable(st_q.level_mode_q))
    else $error("config changed without a write");

  a_sq3_write_lands: assert property (wr_sq3 |=> port3_squelch_field == $past(reg_wdata[2:0]))
    else $error("port 3 squelch write lost");

  a_sq_fields_hold: assert property (!wr_sq3 && !wr_sq12
    |=> $stable(port3_squelch_field) && $stable(port2_squelch_field) && $stable(port1_squelch_field))
    else $error("squelch field changed without a write");

  a_sq3_nominal: assert property (port3_squelch_field == 3'h0 |-> port3_squelch_pct == `HAMS_PCT_NOMINAL)
    else $error("port 3 code zero is not nominal");

  // summary and flags are only set by real events
  a_summary_needs_evt: assert property (!st_q.summary_q && !unmasked_evt |=> !st_q.summary_q)
    else $error("summary set without an unmasked event");

  a_susp_flag_sets: assert property (evt_susp |=> susp_flag)
    else $error("suspend entry did not set its flag");

  a_cfgd_flag_sets: assert property (hub_configured |=> cfgd_flag)
    else $error("configured event did not set its flag");

  a_pwr_flag_sets: assert property (port_power_updated |=> pwr_flag)
    else $error("power update did not set its flag");

  // clocks are never gated while the hub is awake
  a_gate_needs_susp: assert property (!hub_suspended |=> !internal_clock_gate)
    else $error("clock gated while not suspended");
endmodule // hams_regs

//--- tb/hams_host_model.sv
// system processor model acting as serial port master of the register bank
// assumes one-cycle strobes and read data one edge after the read strobe
`timescale 1ns/1ps
module hams_host_model (
  input wire logic clock,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h5a;
    reg_wdata = 8'ha5;
  end

  // status writes carry zero only in the bits meant to clear
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    // released bus shows inverted junk so stale values never match by luck
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule // hams_host_model

//--- tb/hams_regs_bench.sv
// self-checking bench for the alert mask and squelch register bank
// assumes the host model drives the register port and this module the hub events
`timescale 1ns/1ps
`define CHK(a, e, m) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %0t %s", $time, m); end end
module hams_regs_bench import hams_pkg::*;;
  logic clock, rst_b, reg_wr, reg_rd, reg_rvalid, susp, cfgd, pwr, alert_n, gate, vl;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, p1, p2, p3, rv, d;
  hams_squelch_t f1, f2, f3;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  int pct_tab[8] = '{100, 90, 80, 70, 60, 50, 120, 110};
  logic [7:0] ofs[4] = '{8'he9, 8'hee, 8'hf4, 8'hf5};
  logic [7:0] keep[4] = '{8'h1c, 8'hc0, 8'h07, 8'h77};

  hams_host_model i_host (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  hams_regs i_dut (.clock(clock), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .hub_suspended(susp),
    .hub_configured(cfgd), .port_power_updated(pwr), .alert_n(alert_n), .internal_clock_gate(gate),
    .port1_squelch_field(f1), .port2_squelch_field(f2), .port3_squelch_field(f3),
    .port1_squelch_pct(p1), .port2_squelch_pct(p2), .port3_squelch_pct(p3));

  always #12.5 clock = ~clock;

  task automatic print_verdict;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // generous ceiling: the whole sequence needs a few hundred cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, rv, vl);
    `CHK(vl, 1'b1, "rvalid")
    `CHK(rv, e, "read data")
  endtask

  // extra idle edge first so a held suspend level can rise again
  task automatic evt(input int k);
    @(posedge clock);
    susp <= 1'b0;
    @(posedge clock);
    susp <= (k == 0);
    cfgd <= (k == 1);
    pwr <= (k == 2);
    @(posedge clock);
    cfgd <= 1'b0;
    pwr <= 1'b0;
    #1;
  endtask

  initial begin
    clock = 1'b0;
    rst_b = 1'b0;
    {susp, cfgd, pwr} = 3'h0;
    void'($urandom(32'h7529));
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    `CHK(alert_n, 1'b1, "alert idle")
    for (int i = 0; i < 4; i++) chk_rd(ofs[i], 8'h00);
    chk_rd(8'h00, 8'h00);
    repeat (6) for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      i_host.wr(ofs[i], d);
      chk_rd(ofs[i], d & keep[i]);
    end
    for (int c = 0; c < 8; c++) begin
      i_host.wr(8'hf4, 8'(c));
      i_host.wr(8'hf5, 8'((c << 4) | (7 - c)));
      `CHK(f3, 3'(c), "port3 code")
      `CHK(p3, 8'(pct_tab[c]), "port3 pct")
      `CHK(f2, 3'(c), "port2 code")
      `CHK(p2, 8'(pct_tab[c]), "port2 pct")
      `CHK(f1, 3'(7 - c), "port1 code")
      `CHK(p1, 8'(pct_tab[7 - c]), "port1 pct")
    end
    i_host.wr(8'hee, 8'h00);
    for (int k = 0; k < 3; k++) begin
      d = 8'h10 >> k;
      i_host.wr(8'he9, 8'h00);
      evt(k);
      `CHK(alert_n, 1'b1, "masked event")
      if (k == 0) `CHK(gate, 1'b1, "gate in suspend")
      chk_rd(8'he8, d);
      i_host.wr(8'he8, 8'hff);
      chk_rd(8'he8, d);
      i_host.wr(8'he8, 8'h00);
      i_host.wr(8'he9, d);
      evt(k);
      `CHK(alert_n, 1'b0, "unmasked event")
      i_host.wr(8'he8, 8'hff);
      `CHK(alert_n, 1'b0, "alert held")
      chk_rd(8'he8, 8'h80 | d);
      i_host.wr(8'he8, 8'h00);
      `CHK(alert_n, 1'b1, "alert cleared")
      chk_rd(8'he8, 8'h00);
    end
    i_host.wr(8'he9, 8'h00);
    i_host.wr(8'hee, 8'h80);
    evt(0);
    `CHK(gate, 1'b0, "clock kept")
    chk_rd(8'hee, 8'h80);
    i_host.wr(8'hee, 8'h40);
    `CHK(alert_n, 1'b0, "level low")
    @(posedge clock);
    susp <= 1'b0;
    @(posedge clock);
    #1;
    `CHK(alert_n, 1'b1, "level high")
    i_host.wr(8'hee, 8'h00);
    i_host.wr(8'he9, 8'h10);
    evt(0);
    @(posedge clock);
    susp <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    `CHK(alert_n, 1'b0, "event stays")
    print_verdict();
  end
endmodule // hams_regs_bench
